// File: core/mb_handler_defines.vh
`ifndef MB_HANDLER_DEFINES_VH
`define MB_HANDLER_DEFINES_VH

// ----------------------------------------
// Function and exception codes
// ----------------------------------------
`define FC_READ_HOLD 8'h03
`define FC_DIAG 8'h08
`define FC_WRITE_MULTI 8'h10
`define FC_EXC_BIT 8'h80
`define EXC_NONE 8'h00
`define EXC_ILL_FUNC 8'h01
`define EXC_ILL_ADDR 8'h02
`define EXC_ILL_VALUE 8'h03
`define EXC_DEV_FAIL 8'h04
`define BCAST_ADDR 8'h00

// ----------------------------------------
// Limit and default windows
// ----------------------------------------
`define OFS_MIN 16'h2710
`define OFS_MAX 16'h4e20
`define OFS_DEF 16'h7530
`define SEL_DIRECT 2'h0
`define SEL_MIN 2'h1
`define SEL_MAX 2'h2
`define SEL_DEF 2'h3

// ----------------------------------------
// Quantity limits and diagnostics
// ----------------------------------------
`define QTY_MIN 16'h0001
`define QTY_MAX 16'h0010
`define SUB_LOOPBACK 16'h0000
`define SUB_CLEAR_ALL 16'h000a
`define SUB_FIRST_CNT 16'h000b
`define SUB_LAST_CNT 16'h0012
`define SUB_CLEAR_OVR 16'h0014

// ----------------------------------------
// Frame byte positions and lengths
// ----------------------------------------
`define POS_SLAVE 8'h00
`define POS_FUNC 8'h01
`define POS_ADDR_HI 8'h02
`define POS_ADDR_LO 8'h03
`define POS_QTY_HI 8'h04
`define POS_QTY_LO 8'h05
`define POS_BCOUNT 8'h06
`define POS_DATA0 8'h07
`define LEN_FIXED 8'h06
`define LEN_EXC 8'h03
`define LEN_READ_HDR 8'h03
`define LEN_ECHO 8'h06

// ----------------------------------------
// Diagnostic counter slots
// ----------------------------------------
`define CNT_NUM 8
`define CNT_BUS 0
`define CNT_CRC 1
`define CNT_EXC 2
`define CNT_SLV 3
`define CNT_NORESP 4
`define CNT_OVR 7

`endif

// File: core/diag_counter_bank.v
`timescale 1ns/1ps
`default_nettype none

module diag_counter_bank #(
    parameter COUNT = 8,
    parameter WIDTH = 16
) (
    input wire clk_in,                          // System clock
    input wire rst_in,                          // Synchronous reset, high
    input wire [COUNT-1:0] inc_in,              // Count pulses
    input wire [COUNT-1:0] clr_in,              // Clear pulses
    input wire flag_set_in,                     // Overrun flag set pulse
    input wire flag_clr_in,                     // Overrun flag clear pulse
    output wire [COUNT*WIDTH-1:0] counts_out,   // All counters, slot 0 lowest
    output reg flag_out                         // Overrun flag
);

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < COUNT; g = g + 1) begin : g_cnt
            reg [WIDTH-1:0] cnt_reg;
            // Count beats clear, so an event in the clear cycle survives
            always @(posedge clk_in) begin
                if (rst_in) begin
                    cnt_reg <= {WIDTH{1'b0}};
                end else if (inc_in[g]) begin
                    cnt_reg <= clr_in[g] ? {{(WIDTH-1){1'b0}}, 1'b1} : cnt_reg + 1'b1;
                end else if (clr_in[g]) begin
                    cnt_reg <= {WIDTH{1'b0}};
                end
            end
            assign counts_out[g*WIDTH +: WIDTH] = cnt_reg;
        end
    endgenerate

    // Overrun flag, set wins over clear
    always @(posedge clk_in) begin
        if (rst_in) begin
            flag_out <= 1'b0;
        end else if (flag_set_in) begin
            flag_out <= 1'b1;
        end else if (flag_clr_in) begin
            flag_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: core/modbus_request_handler.v
`timescale 1ns/1ps
`default_nettype none
`include "mb_handler_defines.vh"

module modbus_request_handler #(
    parameter [7:0] SLAVE_ADDR = 8'h01
) (
    input wire REF_CLK_IN,              // System clock, 10 MHz
    input wire SYS_RST_IN,              // Synchronous reset, high
    input wire [7:0] RX_DATA_IN,        // Frame byte, CRC stripped
    input wire RX_VALID_IN,             // Frame byte strobe
    input wire RX_END_IN,               // End of frame pulse
    input wire RX_CRC_OK_IN,            // Frame CRC good, with end pulse
    input wire RX_OVERRUN_IN,           // Character overrun, with end pulse
    input wire PASSWORD_OK_IN,          // Write access granted
    input wire MAP_DEFINED_IN,          // Address inside valid space
    input wire MAP_HIT_IN,              // Address is a mapped register
    input wire MAP_FIRST_IN,            // First register of its item
    input wire MAP_LAST_IN,             // Last register of its item
    input wire MAP_WRITABLE_IN,         // Register is writable
    input wire [15:0] MAP_VALUE_IN,     // Register value
    input wire [15:0] MAP_MIN_IN,       // Register minimum
    input wire [15:0] MAP_MAX_IN,       // Register maximum
    input wire [15:0] MAP_DEFAULT_IN,   // Register default
    output reg [15:0] MAP_ADDR_OUT,     // Register map address
    output reg MAP_WR_OUT,              // Register write pulse
    output reg [15:0] MAP_WDATA_OUT,    // Register write data
    output reg [7:0] TX_DATA_OUT,       // Response byte, CRC added later
    output reg TX_VALID_OUT,            // Response byte valid
    output reg TX_LAST_OUT,             // Last response byte
    input wire TX_READY_IN,             // Serializer takes byte
    output wire OVERRUN_FLAG_OUT        // Overrun flag
);

    // ----------------------------------------
    // States and storage
    // ----------------------------------------
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_CHECK = 5'h02;
    localparam [4:0] S_WALK = 5'h04;
    localparam [4:0] S_COMMIT = 5'h08;
    localparam [4:0] S_SEND = 5'h10;
    localparam CW = 16;

    reg [4:0] state_reg;
    reg [7:0] rx_cnt_reg;
    reg [7:0] slave_reg;
    reg [7:0] func_reg;
    reg [15:0] start_addr_reg;
    reg [15:0] register_quantity_field_reg;
    reg [7:0] payload_byte_total_reg;
    reg [15:0] word_mem [0:15];
    reg crc_ok_reg;
    reg ovr_reg;
    reg [4:0] idx_reg;
    reg phase_reg;
    reg [7:0] exc_reg;
    reg [15:0] echo_word_reg;
    reg [7:0] resp_len_reg;
    reg [7:0] tx_idx_reg;
    reg [`CNT_NUM-1:0] inc_reg;
    reg [`CNT_NUM-1:0] clr_reg;
    reg flag_set_reg;
    reg flag_clr_reg;
    wire [`CNT_NUM*CW-1:0] counts;

    // Splits an address into window select and base register
    function [17:0] split_addr;
        input [15:0] a;
        begin
            if (a >= `OFS_DEF) split_addr = {`SEL_DEF, a - `OFS_DEF};
            else if (a >= `OFS_MAX) split_addr = {`SEL_MAX, a - `OFS_MAX};
            else if (a >= `OFS_MIN) split_addr = {`SEL_MIN, a - `OFS_MIN};
            else split_addr = {`SEL_DIRECT, a};
        end
    endfunction

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    wire [15:0] qty = register_quantity_field_reg;
    wire [15:0] cur_addr = start_addr_reg + {11'h000, idx_reg};
    wire [17:0] cur_split = split_addr(cur_addr);
    wire [1:0] cur_sel = cur_split[17:16];
    wire [15:0] cur_base = cur_split[15:0];
    wire last_idx = ({11'h000, idx_reg} == qty - 16'h0001);
    wire is_write = (func_reg == `FC_WRITE_MULTI);
    wire is_bcast = (slave_reg == `BCAST_ADDR);
    wire for_us = (slave_reg == SLAVE_ADDR) || is_bcast;
    wire [15:0] sub_ofs = start_addr_reg - `SUB_FIRST_CNT;
    wire [2:0] cnt_sel = sub_ofs[2:0];
    wire [15:0] cnt_val = counts[cnt_sel*CW +: CW];
    wire is_cnt_sub = (start_addr_reg >= `SUB_FIRST_CNT) && (start_addr_reg <= `SUB_LAST_CNT);
    wire [15:0] cur_word = word_mem[idx_reg[3:0]];
    wire [7:0] data_ofs = rx_cnt_reg - `POS_DATA0;
    wire [7:0] tx_ofs = tx_idx_reg - `LEN_READ_HDR;
    wire [15:0] tx_word = word_mem[tx_ofs[4:1]];

    // Request checks before any register is touched
    reg [7:0] chk_exc;
    always @* begin
        chk_exc = `EXC_NONE;
        case (func_reg)
            `FC_READ_HOLD: begin
                if (rx_cnt_reg != `LEN_FIXED || qty < `QTY_MIN || qty > `QTY_MAX)
                    chk_exc = `EXC_ILL_VALUE;
            end
            `FC_WRITE_MULTI: begin
                if (qty < `QTY_MIN || qty > `QTY_MAX)
                    chk_exc = `EXC_ILL_VALUE;
                else if ({8'h00, payload_byte_total_reg} != {qty[14:0], 1'b0})
                    chk_exc = `EXC_ILL_VALUE;
                else if (rx_cnt_reg != `POS_DATA0 + payload_byte_total_reg)
                    chk_exc = `EXC_ILL_VALUE;
            end
            `FC_DIAG: begin
                if (rx_cnt_reg != `LEN_FIXED)
                    chk_exc = `EXC_ILL_VALUE;
                else if (!(start_addr_reg == `SUB_LOOPBACK || start_addr_reg == `SUB_CLEAR_ALL ||
                           is_cnt_sub || start_addr_reg == `SUB_CLEAR_OVR))
                    chk_exc = `EXC_ILL_FUNC;
            end
            default: chk_exc = `EXC_ILL_FUNC;
        endcase
    end

    // Per-register verdict while walking the map
    reg [7:0] walk_exc;
    reg [15:0] pick_word;
    always @* begin
        walk_exc = `EXC_NONE;
        case (cur_sel)
            `SEL_MIN: pick_word = MAP_MIN_IN;
            `SEL_MAX: pick_word = MAP_MAX_IN;
            `SEL_DEF: pick_word = MAP_DEFAULT_IN;
            default: pick_word = MAP_VALUE_IN;
        endcase
        // Limit windows exist only for writable registers; others act as holes
        if (!MAP_HIT_IN || (cur_sel != `SEL_DIRECT && !MAP_WRITABLE_IN))
            pick_word = 16'h0000;
        if (!MAP_DEFINED_IN) begin
            walk_exc = `EXC_ILL_ADDR;
        end else if (is_write) begin
            if (idx_reg == 5'h00 && !(MAP_HIT_IN && MAP_FIRST_IN))
                walk_exc = `EXC_ILL_ADDR;
            else if (MAP_HIT_IN && (cur_sel != `SEL_DIRECT || !MAP_WRITABLE_IN))
                walk_exc = `EXC_DEV_FAIL;
            else if (MAP_HIT_IN && !PASSWORD_OK_IN)
                walk_exc = `EXC_DEV_FAIL;
            else if (MAP_HIT_IN && (cur_word < MAP_MIN_IN || cur_word > MAP_MAX_IN))
                walk_exc = `EXC_DEV_FAIL;
            else if (MAP_HIT_IN && last_idx && !MAP_LAST_IN)
                walk_exc = `EXC_DEV_FAIL;
        end
    end

    // Response byte for the current send position
    reg [7:0] resp_byte;
    always @* begin
        if (tx_idx_reg == `POS_SLAVE)
            resp_byte = SLAVE_ADDR;
        else if (tx_idx_reg == `POS_FUNC)
            resp_byte = (exc_reg != `EXC_NONE) ? (func_reg | `FC_EXC_BIT) : func_reg;
        else if (exc_reg != `EXC_NONE)
            resp_byte = exc_reg;
        else if (func_reg == `FC_READ_HOLD)
            resp_byte = (tx_idx_reg == `POS_ADDR_HI) ? {qty[6:0], 1'b0} :
                        (tx_ofs[0] ? tx_word[7:0] : tx_word[15:8]);
        else begin
            case (tx_idx_reg)
                `POS_ADDR_HI: resp_byte = start_addr_reg[15:8];
                `POS_ADDR_LO: resp_byte = start_addr_reg[7:0];
                `POS_QTY_HI: resp_byte = echo_word_reg[15:8];
                default: resp_byte = echo_word_reg[7:0];
            endcase
        end
    end

    // ----------------------------------------
    // Word storage: write data and read results
    // ----------------------------------------
    always @(posedge REF_CLK_IN) begin
        if (state_reg == S_IDLE && RX_VALID_IN && is_write && rx_cnt_reg >= `POS_DATA0 &&
            data_ofs[7:5] == 3'h0) begin
            if (data_ofs[0])
                word_mem[data_ofs[4:1]][7:0] <= RX_DATA_IN;
            else
                word_mem[data_ofs[4:1]][15:8] <= RX_DATA_IN;
        end else if (state_reg == S_WALK && phase_reg && !is_write) begin
            word_mem[idx_reg[3:0]] <= pick_word;
        end
    end

    // Ends a request: answer, or stay silent for broadcast
    task finish;
        input [7:0] len;
        input [7:0] code;
        begin
            idx_reg <= 5'h00;
            phase_reg <= 1'b0;
            exc_reg <= code;
            if (is_bcast) begin
                state_reg <= S_IDLE;
                inc_reg[`CNT_NORESP] <= 1'b1;
            end else begin
                state_reg <= S_SEND;
                resp_len_reg <= len;
                tx_idx_reg <= 8'h00;
                inc_reg[`CNT_EXC] <= (code != `EXC_NONE);
            end
        end
    endtask

    // ----------------------------------------
    // Request state machine
    // ----------------------------------------
    always @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            state_reg <= S_IDLE;
            rx_cnt_reg <= 8'h00;
            slave_reg <= 8'h00;
            func_reg <= 8'h00;
            start_addr_reg <= 16'h0000;
            register_quantity_field_reg <= 16'h0000;
            payload_byte_total_reg <= 8'h00;
            crc_ok_reg <= 1'b0;
            ovr_reg <= 1'b0;
            idx_reg <= 5'h00;
            phase_reg <= 1'b0;
            exc_reg <= `EXC_NONE;
            echo_word_reg <= 16'h0000;
            resp_len_reg <= 8'h00;
            tx_idx_reg <= 8'h00;
            TX_DATA_OUT <= 8'h00;
            TX_VALID_OUT <= 1'b0;
            TX_LAST_OUT <= 1'b0;
            MAP_ADDR_OUT <= 16'h0000;
            MAP_WR_OUT <= 1'b0;
            MAP_WDATA_OUT <= 16'h0000;
            inc_reg <= {`CNT_NUM{1'b0}};
            clr_reg <= {`CNT_NUM{1'b0}};
            flag_set_reg <= 1'b0;
            flag_clr_reg <= 1'b0;
        end else begin
            inc_reg <= {`CNT_NUM{1'b0}};
            clr_reg <= {`CNT_NUM{1'b0}};
            flag_set_reg <= 1'b0;
            flag_clr_reg <= 1'b0;
            MAP_WR_OUT <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (RX_VALID_IN) begin
                        rx_cnt_reg <= (rx_cnt_reg == 8'hff) ? rx_cnt_reg : rx_cnt_reg + 8'h01;
                        case (rx_cnt_reg)
                            `POS_SLAVE: slave_reg <= RX_DATA_IN;
                            `POS_FUNC: func_reg <= RX_DATA_IN;
                            `POS_ADDR_HI: start_addr_reg[15:8] <= RX_DATA_IN;
                            `POS_ADDR_LO: start_addr_reg[7:0] <= RX_DATA_IN;
                            `POS_QTY_HI: register_quantity_field_reg[15:8] <= RX_DATA_IN;
                            `POS_QTY_LO: register_quantity_field_reg[7:0] <= RX_DATA_IN;
                            `POS_BCOUNT: payload_byte_total_reg <= RX_DATA_IN;
                            default: rx_cnt_reg <= rx_cnt_reg + {7'h00, rx_cnt_reg != 8'hff};
                        endcase
                    end else if (RX_END_IN) begin
                        crc_ok_reg <= RX_CRC_OK_IN;
                        ovr_reg <= RX_OVERRUN_IN;
                        inc_reg[`CNT_BUS] <= 1'b1;
                        inc_reg[`CNT_CRC] <= !RX_CRC_OK_IN;
                        // Overrun only counts frames meant for this slave
                        if (RX_CRC_OK_IN && RX_OVERRUN_IN && rx_cnt_reg != 8'h00 && for_us) begin
                            inc_reg[`CNT_OVR] <= 1'b1;
                            flag_set_reg <= 1'b1;
                        end
                        if (rx_cnt_reg != 8'h00)
                            state_reg <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    rx_cnt_reg <= 8'h00;
                    if (!crc_ok_reg || ovr_reg || !for_us || rx_cnt_reg < `LEN_EXC) begin
                        state_reg <= S_IDLE;
                    end else begin
                        inc_reg[`CNT_SLV] <= 1'b1;
                        if (chk_exc != `EXC_NONE) begin
                            finish(`LEN_EXC, chk_exc);
                        end else if (func_reg == `FC_DIAG) begin
                            echo_word_reg <= is_cnt_sub ? cnt_val : register_quantity_field_reg;
                            if (start_addr_reg == `SUB_CLEAR_ALL) begin
                                clr_reg <= {`CNT_NUM{1'b1}};
                                flag_clr_reg <= 1'b1;
                            end
                            if (start_addr_reg == `SUB_CLEAR_OVR) begin
                                clr_reg[`CNT_OVR] <= 1'b1;
                                flag_clr_reg <= 1'b1;
                            end
                            finish(`LEN_ECHO, `EXC_NONE);
                        end else begin
                            echo_word_reg <= register_quantity_field_reg;
                            idx_reg <= 5'h00;
                            phase_reg <= 1'b0;
                            state_reg <= S_WALK;
                        end
                    end
                end
                S_WALK: begin
                    // Map answers one cycle after the address is presented
                    if (!phase_reg) begin
                        MAP_ADDR_OUT <= cur_base;
                        phase_reg <= 1'b1;
                    end else begin
                        phase_reg <= 1'b0;
                        if (walk_exc != `EXC_NONE)
                            finish(`LEN_EXC, walk_exc);
                        else if (!last_idx)
                            idx_reg <= idx_reg + 5'h01;
                        else if (is_write) begin
                            idx_reg <= 5'h00;
                            state_reg <= S_COMMIT;
                        end else
                            finish(`LEN_READ_HDR + {qty[6:0], 1'b0}, `EXC_NONE);
                    end
                end
                S_COMMIT: begin
                    // Second pass writes only after the whole request proved clean
                    if (!phase_reg) begin
                        MAP_ADDR_OUT <= cur_base;
                        phase_reg <= 1'b1;
                    end else begin
                        phase_reg <= 1'b0;
                        MAP_WR_OUT <= MAP_HIT_IN && MAP_WRITABLE_IN;
                        MAP_WDATA_OUT <= cur_word;
                        if (last_idx)
                            finish(`LEN_ECHO, `EXC_NONE);
                        else
                            idx_reg <= idx_reg + 5'h01;
                    end
                end
                S_SEND: begin
                    if (TX_VALID_OUT && TX_READY_IN && TX_LAST_OUT) begin
                        TX_VALID_OUT <= 1'b0;
                        TX_LAST_OUT <= 1'b0;
                        state_reg <= S_IDLE;
                    end else if (!TX_VALID_OUT || TX_READY_IN) begin
                        TX_DATA_OUT <= resp_byte;
                        TX_VALID_OUT <= 1'b1;
                        TX_LAST_OUT <= (tx_idx_reg == resp_len_reg - 8'h01);
                        tx_idx_reg <= tx_idx_reg + 8'h01;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Diagnostic counters
    // ----------------------------------------
    diag_counter_bank #(
        .COUNT(`CNT_NUM),
        .WIDTH(CW)
    ) u_counters (
        .clk_in(REF_CLK_IN),
        .rst_in(SYS_RST_IN),
        .inc_in(inc_reg),
        .clr_in(clr_reg),
        .flag_set_in(flag_set_reg),
        .flag_clr_in(flag_clr_reg),
        .counts_out(counts),
        .flag_out(OVERRUN_FLAG_OUT)
    );

endmodule

`default_nettype wire

// File: test/mb_handler_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mb_handler_asserts (
    input wire logic REF_CLK_IN, // Clock
    input wire logic SYS_RST_IN, // Reset
    input wire logic RX_END_IN, // Frame end
    input wire logic RX_CRC_OK_IN, // CRC good
    input wire logic PASSWORD_OK_IN, // Access
    input wire logic MAP_HIT_IN, // Mapped
    input wire logic MAP_WRITABLE_IN, // Writable
    input wire logic MAP_WR_OUT, // Write pulse
    input wire logic [7:0] TX_DATA_OUT, // Byte
    input wire logic TX_VALID_OUT, // Valid
    input wire logic TX_LAST_OUT, // Last
    input wire logic TX_READY_IN // Ready
);
    // One domain; reset silences every check
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    property p_hold; TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT); endproperty
    a_hold: assert property (p_hold) else $error("byte not held");
    property p_last; TX_LAST_OUT |-> TX_VALID_OUT; endproperty
    a_last: assert property (p_last) else $error("last alone");
    property p_idle; TX_VALID_OUT && TX_READY_IN && TX_LAST_OUT |=> !TX_VALID_OUT; endproperty
    a_idle: assert property (p_idle) else $error("byte after last");
    property p_crc; RX_END_IN && !RX_CRC_OK_IN |=> !TX_VALID_OUT [*8]; endproperty
    a_crc: assert property (p_crc) else $error("bad frame answered");
    property p_pw; MAP_WR_OUT |-> PASSWORD_OK_IN; endproperty
    a_pw: assert property (p_pw) else $error("write no access");
    property p_ro; MAP_WR_OUT |-> MAP_WRITABLE_IN; endproperty
    a_ro: assert property (p_ro) else $error("write read-only");
    property p_hole; MAP_WR_OUT |-> MAP_HIT_IN; endproperty
    a_hole: assert property (p_hole) else $error("write hole");
    property p_quiet; MAP_WR_OUT |-> !TX_VALID_OUT; endproperty
    a_quiet: assert property (p_quiet) else $error("echo early");
    // Main traffic seen
    c_wr: cover property (MAP_WR_OUT);
    c_end: cover property (TX_LAST_OUT && TX_READY_IN);
    c_bad: cover property (RX_END_IN && !RX_CRC_OK_IN);
endmodule
`default_nettype wire

// File: test/reg_map_model.sv
`timescale 1ns/1ps
`default_nettype none
module reg_map_model (
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic [15:0] addr_in, // Address
    input wire logic wr_in, // Write
    input wire logic [15:0] wd_in, // Data
    output logic def_out, // In space
    output logic hit_out, // Mapped
    output logic fst_out, // Item start
    output logic lst_out, // Item end
    output logic wrt_out, // Writable
    output logic [15:0] val_out // Value
);
    logic [15:0] mem_reg [0:15];
    // 0-7 float pairs, 0-3 read-only, 8-15 words, holes show junk so zeros must come from the handler
    assign def_out = addr_in < 16'h0020;
    assign hit_out = addr_in < 16'h0010;
    assign fst_out = hit_out && (addr_in[3] || !addr_in[0]);
    assign lst_out = hit_out && (addr_in[3] || addr_in[0]);
    assign wrt_out = hit_out && addr_in > 16'h0003;
    assign val_out = hit_out ? mem_reg[addr_in[3:0]] : 16'ha5a5;
    // Power-up pattern 0x40 plus index
    always @(posedge clk_in)
        for (int i = 0; i < 16; i++)
            mem_reg[i] <= rst_in ? 16'h0040 + 16'(i) : (wr_in && addr_in == 16'(i)) ? wd_in : mem_reg[i];
endmodule
`default_nettype wire

// File: test/modbus_rtu_slave_request_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module modbus_rtu_slave_request_handler_test;
    typedef logic [7:0] bq[$];
    typedef logic [15:0] wq[$];
    logic clk = 0, rst = 1, rxv = 0, rxe = 0, crc = 1, ovr = 0, pw = 1, rdy = 0;
    logic def, hit, fst, lst, wrt, mwr, txv, txl, flg;
    logic [7:0] rxd = 8'h00, txd, eb;
    logic [15:0] val, adr, wd, w;
    logic [31:0] lfsr = 32'h98294743;
    bq expq, nil;
    int fails = 0, tests_run = 0, exc_n = 0, cyc = 0;
    modbus_request_handler modbus_request_handler_inst (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .RX_DATA_IN(rxd),
        .RX_VALID_IN(rxv), .RX_END_IN(rxe), .RX_CRC_OK_IN(crc), .RX_OVERRUN_IN(ovr), .PASSWORD_OK_IN(pw),
        .MAP_DEFINED_IN(def), .MAP_HIT_IN(hit), .MAP_FIRST_IN(fst), .MAP_LAST_IN(lst), .MAP_WRITABLE_IN(wrt),
        .MAP_VALUE_IN(val), .MAP_MIN_IN(16'h0010), .MAP_MAX_IN(16'h0100), .MAP_DEFAULT_IN(16'h0020),
        .MAP_ADDR_OUT(adr), .MAP_WR_OUT(mwr), .MAP_WDATA_OUT(wd), .TX_DATA_OUT(txd), .TX_VALID_OUT(txv),
        .TX_LAST_OUT(txl), .TX_READY_IN(rdy), .OVERRUN_FLAG_OUT(flg));
    reg_map_model reg_map_model_inst (.clk_in(clk), .rst_in(rst), .addr_in(adr), .wr_in(mwr), .wd_in(wd),
        .def_out(def), .hit_out(hit), .fst_out(fst), .lst_out(lst), .wrt_out(wrt), .val_out(val));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic bq f6(input logic [7:0] fc, input logic [15:0] a, b);
        return '{8'h01, fc, a[15:8], a[7:0], b[15:8], b[7:0]};
    endfunction
    task automatic final_report;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Send one frame, note its answer, wait until the answer is drained
    task automatic fr(input bq f, e);
        int n = 0;
        expq = {expq, e};
        foreach (f[i]) begin
            rxv <= 1'b1;
            rxd <= f[i];
            @(posedge clk);
        end
        rxv <= 1'b0;
        rxe <= 1'b1;
        @(posedge clk);
        rxe <= 1'b0;
        while (expq.size() != 0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        // A stalled answer leaves notes behind and must count as a miss
        `CHK("tx_drain", 0, expq.size())
        expq.delete();
    endtask
    task automatic ex(input bq f, input logic [7:0] c);
        exc_n++;
        fr(f, '{8'h01, f[1] | 8'h80, c});
    endtask
    task automatic rd(input logic [15:0] a, input wq v);
        bq e = '{8'h01, 8'h03, 8'(2 * v.size())};
        foreach (v[i]) e = {e, v[i][15:8], v[i][7:0]};
        fr(f6(8'h03, a, 16'(v.size())), e);
    endtask
    task automatic wr(input logic [15:0] a, input wq v, input logic [7:0] c);
        bq f = f6(8'h10, a, 16'(v.size()));
        f.push_back(8'(2 * v.size()));
        foreach (v[i]) f = {f, v[i][15:8], v[i][7:0]};
        if (c == 8'h00)
            fr(f, f[0:5]);
        else
            ex(f, c);
    endtask
    task automatic dg(input logic [15:0] s, r);
        fr(f6(8'h08, s, 16'h0000), f6(8'h08, s, r));
    endtask
    always #50 clk = ~clk;
    // Noise stalls the serializer side; a cycle ceiling cuts a hang short
    always @(posedge clk) begin
        lfsr <= nx(lfsr);
        rdy <= lfsr[0] | lfsr[2];
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            final_report;
        end
    end
    // Each taken byte against the oldest note
    always @(posedge clk) begin
        if (txv && rdy) begin
            eb = expq.size() != 0 ? expq.pop_front() : 8'hxx;
            `CHK("tx_byte", eb, txd)
            `CHK("tx_last", expq.size() == 0, txl)
        end
    end
    // Reset, then one frame per case
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        w = 16'h0010 + {9'h000, lfsr[6:0]};
        rd(16'h0008, '{16'h0048, 16'h0049});
        rd(16'h000e, '{16'h004e, 16'h004f, 16'h0000, 16'h0000});
        rd(16'h2718, '{16'h0010});
        rd(16'h4e28, '{16'h0100});
        rd(16'h7538, '{16'h0020});
        ex(f6(8'h03, 16'h0008, 16'h0011), 8'h03);
        ex(f6(8'h03, 16'h001f, 16'h0002), 8'h02);
        ex(f6(8'h05, 16'h0008, 16'h0001), 8'h01);
        wr(16'h0008, '{w}, 8'h00);
        rd(16'h0008, '{w});
        wr(16'h000f, '{w, w}, 8'h00);
        wr(16'h0000, '{w, w}, 8'h04);
        wr(16'h0005, '{w}, 8'h02);
        wr(16'h0004, '{w}, 8'h04);
        wr(16'h0008, '{16'h0101}, 8'h04);
        ex('{8'h01, 8'h10, 8'h00, 8'h08, 8'h00, 8'h11, 8'h22}, 8'h03);
        ex('{8'h01, 8'h10, 8'h00, 8'h08, 8'h00, 8'h01, 8'h04, 8'h00, 8'h20, 8'h00, 8'h20}, 8'h03);
        pw <= 1'b0;
        wr(16'h0008, '{w}, 8'h04);
        pw <= 1'b1;
        fr(f6(8'h08, 16'h0000, w), f6(8'h08, 16'h0000, w));
        crc <= 1'b0;
        fr(f6(8'h03, 16'h0008, 16'h0001), nil);
        crc <= 1'b1;
        dg(16'h000c, 16'h0001);
        dg(16'h000d, 16'(exc_n));
        ovr <= 1'b1;
        fr(f6(8'h03, 16'h0008, 16'h0001), nil);
        ovr <= 1'b0;
        `CHK("overrun_flag", 1'b1, flg)
        dg(16'h0012, 16'h0001);
        dg(16'h0014, 16'h0000);
        `CHK("overrun_flag", 1'b0, flg)
        dg(16'h000c, 16'h0001);
        dg(16'h000a, 16'h0000);
        dg(16'h000e, 16'h0001);
        dg(16'h000d, 16'h0000);
        dg(16'h0011, 16'h0000);
        dg(16'h000b, 16'h0003);
        final_report;
    end
endmodule
bind modbus_request_handler mb_handler_asserts mb_handler_asserts_inst (.REF_CLK_IN, .SYS_RST_IN, .RX_END_IN,
    .RX_CRC_OK_IN, .PASSWORD_OK_IN, .MAP_HIT_IN, .MAP_WRITABLE_IN, .MAP_WR_OUT, .TX_DATA_OUT, .TX_VALID_OUT,
    .TX_LAST_OUT, .TX_READY_IN);
`default_nettype wire
